// ### include/tec_cfg.svh
// Register offsets, field positions, reset values and widths for the timer/event counter.
// Assumes an APB slave with 32-bit data, one register per aligned word.
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH
`define TEC_OFS_CTRL      12'h000
`define TEC_OFS_PRELOAD   12'h004
`define TEC_OFS_COUNT     12'h008
`define TEC_OFS_STATUS    12'h00C
`define TEC_OFS_IRQCTL    12'h010
`define TEC_OFS_SYSCTL    12'h014
`define TEC_CTRL_PSC_LSB  0
`define TEC_CTRL_EDGE_BIT 3
`define TEC_CTRL_RUN_BIT  4
`define TEC_CTRL_MODE_LSB 6
`define TEC_CTRL_RST      8'h00
`define TEC_CNT_WIDTH     8
`define TEC_SYNC_STAGES   2
`endif

// ### include/tec_pkg.sv
// Types shared by the timer/event counter design files.
// Assumes the constants of tec_cfg.svh are included where numbers are needed.
package tec_pkg;
    typedef enum logic [1:0] {
        TEC_MODE_OFF   = 2'b00,
        TEC_MODE_EVENT = 2'b01,
        TEC_MODE_TIMER = 2'b10,
        TEC_MODE_PWC   = 2'b11
    } tec_mode_t;
    typedef enum logic [1:0] {
        TEC_PWC_IDLE,
        TEC_PWC_ARMED,
        TEC_PWC_MEASURE
    } tec_pwc_state_t;
endpackage : tec_pkg

// ### rtl/tec_pin_sync.sv
// Two-stage synchroniser plus edge detector for the external count pin.
// Assumes the pin is asynchronous to i_clk; only the second stage feeds logic.
`timescale 1ns/10ps
module tec_pin_sync #(
    parameter int STAGES = 2
) (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic [STAGES-1:0] sync;
    logic              last;

    if (STAGES < 2)
    begin : g_bad_stages
        $error("tec_pin_sync needs at least two stages");
    end

    // The pin idles high through its pull-high, so the chain resets high to avoid a false rise.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync <= '1;
            last <= 1'b1;
        end
        else
        begin
            sync <= {sync[STAGES-2:0], i_pin};  // [R20]
            last <= sync[STAGES-1];
        end
    end

    assign o_level = sync[STAGES-1];
    assign o_rise  = sync[STAGES-1] & ~last;  // [R07]
    assign o_fall  = ~sync[STAGES-1] & last;  // [R07]
endmodule : tec_pin_sync

// ### rtl/tec_top.sv
// Timer/event counter with timer, event count and pulse width capture modes, APB registers.
// Assumes a single 100 MHz system clock; the count pin is asynchronous and synchronised here.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "tec_cfg.svh"

// Functional notes
// [R01] Event and capture modes use the external pin.
// [R02] Software selects mode and sets pin input.
// [R03] Timer mode counts prescaled system clock.
// [R04] Timer overflow raises the timer interrupt.
// [R05] Capture counts clock only while pin qualifies.
// [R06] Pin changes act at next timer clock.
// [R07] Event edges treated as unsynchronised inputs.
// [R08] Counter read or preload write inhibits counting.
// [R09] Interrupt stays off unless software enables it.
// [R10] Software loads initial value before enabling.
// [R11] Run bit 4 starts and stops counter.
// [R12] Overflow sets flag; interrupt only if enabled.
// [R13] Overflow in power-down wakes regardless of enable.
// [R14] Event counting continues during power-down.
// [R15] Software sets flag before power-down to avoid wake.
// [R16] Mode pair: timer 10, event 01, capture 11.
// [R17] Edge bit low rising, high falling.
// [R18] Overflow reloads preload and keeps counting.
// [R19] Capture end clears run bit, ignores edges.
// [R20] Pin passes two-stage synchroniser first.
// [R21] Wake-up is a one-cycle overflow pulse.
module tec_top #(
    parameter int CNT_WIDTH = `TEC_CNT_WIDTH
) (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_external_count_pin,
    input  wire logic        i_power_down,
    output logic             o_irq,
    output logic             o_wakeup,
    output logic             o_pin_dir_in
);
    logic [7:0]             ctrl;
    logic [CNT_WIDTH-1:0]   preload;
    logic [CNT_WIDTH-1:0]   count;
    logic                   irq_flag;
    logic                   irq_en;
    logic                   pin_dir;
    logic                   wake;
    logic [6:0]             psc_cnt;
    tec_pkg::tec_pwc_state_t pwc_state;

    if (CNT_WIDTH < 2 || CNT_WIDTH > 32)
    begin : g_bad_width
        $error("tec_top CNT_WIDTH must be 2..32");
    end

    // Pin conditioning.
    wire pin_level;
    wire pin_rise;
    wire pin_fall;
    tec_pin_sync #(
        .STAGES (`TEC_SYNC_STAGES)
    ) u_sync (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_pin   (i_external_count_pin),
        .o_level (pin_level),
        .o_rise  (pin_rise),
        .o_fall  (pin_fall)
    );

    // APB decode. Zero wait states: every access completes in its first access cycle.
    wire acc       = i_psel & i_penable;
    wire wr        = acc & i_pwrite;
    wire rd        = acc & ~i_pwrite;
    wire sel_ctrl  = i_paddr == `TEC_OFS_CTRL;
    wire sel_pre   = i_paddr == `TEC_OFS_PRELOAD;
    wire sel_cnt   = i_paddr == `TEC_OFS_COUNT;
    wire sel_stat  = i_paddr == `TEC_OFS_STATUS;
    wire sel_irq   = i_paddr == `TEC_OFS_IRQCTL;
    wire sel_sys   = i_paddr == `TEC_OFS_SYSCTL;
    wire mapped    = sel_ctrl | sel_pre | sel_cnt | sel_stat | sel_irq | sel_sys;

    // Control fields.
    wire [2:0] psc_sel  = ctrl[`TEC_CTRL_PSC_LSB +: 3];
    wire       edge_sel = ctrl[`TEC_CTRL_EDGE_BIT];
    wire       run      = ctrl[`TEC_CTRL_RUN_BIT];  // [R11]
    wire tec_pkg::tec_mode_t mode = tec_pkg::tec_mode_t'(ctrl[`TEC_CTRL_MODE_LSB +: 2]);  // [R16]

    // Prescaler tick: divide by 2**psc_sel. A counter read or preload write clears it too.
    wire [6:0] psc_mask  = 7'((8'h01 << psc_sel) - 8'h01);
    wire       psc_tick  = (psc_cnt & psc_mask) == 7'h00;
    wire       inhibit   = (rd & sel_cnt) | (wr & sel_pre);  // [R08]

    // Active edge for event mode, and leading/trailing edges for capture mode.
    wire ev_edge   = edge_sel ? pin_fall : pin_rise;  // [R17]
    wire pw_lead   = edge_sel ? pin_rise : pin_fall;  // [R17]
    wire pw_trail  = edge_sel ? pin_fall : pin_rise;
    wire pw_active = edge_sel ? pin_level : ~pin_level;  // [R05]

    wire measuring = pwc_state == tec_pkg::TEC_PWC_MEASURE;
    wire pwc_done  = run && (mode == tec_pkg::TEC_MODE_PWC) && measuring && pw_trail;  // [R19]

    // Count step per mode; pin activity only seen via the synchronised level.
    wire step_timer = (mode == tec_pkg::TEC_MODE_TIMER) & psc_tick;  // [R03]
    wire step_event = (mode == tec_pkg::TEC_MODE_EVENT) & ev_edge;  // [R01] [R14]
    wire step_pwc   = (mode == tec_pkg::TEC_MODE_PWC) & measuring & pw_active & psc_tick;  // [R01] [R06]
    wire step       = run & ~inhibit & (step_timer | step_event | step_pwc);
    wire overflow   = step & (count == {CNT_WIDTH{1'b1}});

    wire [CNT_WIDTH-1:0] next_count = overflow ? preload : count + 1'b1;  // [R18]

    wire [31:0] rd_mux =
        sel_ctrl ? {24'h000000, ctrl} :
        sel_pre  ? 32'(preload) :
        sel_cnt  ? 32'(count) :
        sel_stat ? {30'h00000000, measuring, irq_flag} :
        sel_irq  ? {31'h00000000, irq_en} :
        sel_sys  ? {31'h00000000, pin_dir} :
        32'h00000000;

    assign o_pready     = 1'b1;
    assign o_pslverr    = acc & ~mapped;
    assign o_irq        = irq_flag & irq_en;  // [R04] [R09] [R12]
    assign o_wakeup     = wake;
    assign o_pin_dir_in = pin_dir;  // [R02]

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            psc_cnt <= 7'h00;
        else if (!(run && !inhibit))
            psc_cnt <= 7'h00;
        else
            psc_cnt <= psc_cnt + 7'h01;
    end

    // Software writes win over the auto clear for every field, run included.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ctrl <= `TEC_CTRL_RST;
        else if (wr && sel_ctrl)
            ctrl <= i_pwdata[7:0];  // [R11]
        else if (pwc_done)
            ctrl[`TEC_CTRL_RUN_BIT] <= 1'b0;  // [R19]
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            pwc_state <= tec_pkg::TEC_PWC_IDLE;
        else if (!run || mode != tec_pkg::TEC_MODE_PWC)
            pwc_state <= tec_pkg::TEC_PWC_ARMED;
        else
        begin
            unique case (pwc_state)
                tec_pkg::TEC_PWC_IDLE:    pwc_state <= tec_pkg::TEC_PWC_ARMED;
                tec_pkg::TEC_PWC_ARMED:   if (pw_lead) pwc_state <= tec_pkg::TEC_PWC_MEASURE;
                tec_pkg::TEC_PWC_MEASURE: if (pw_trail) pwc_state <= tec_pkg::TEC_PWC_IDLE;  // [R19]
                default:                  pwc_state <= tec_pkg::TEC_PWC_IDLE;
            endcase
        end
    end

    // Counter and preload have no meaningful start value; software loads them first.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            preload <= '0;
            count   <= '0;  // [R10]
        end
        else
        begin
            if (wr && sel_pre)
                preload <= i_pwdata[CNT_WIDTH-1:0];
            if (wr && sel_cnt)
                count <= i_pwdata[CNT_WIDTH-1:0];
            else if (step)
                count <= next_count;
        end
    end

    // Overflow set wins over a software clear in the same cycle.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            irq_flag <= 1'b0;
        else if (overflow)
            irq_flag <= 1'b1;  // [R12]
        else if (wr && sel_stat)
            irq_flag <= i_pwdata[0];  // [R15]
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            irq_en  <= 1'b0;
            pin_dir <= 1'b0;
        end
        else
        begin
            if (wr && sel_irq)
                irq_en <= i_pwdata[0];  // [R09]
            if (wr && sel_sys)
                pin_dir <= i_pwdata[0];
        end
    end

    // A set flag suppresses the wake pulse, so software can block it before power-down.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            wake <= 1'b0;
        else
            wake <= overflow & i_power_down & ~irq_flag;  // [R13] [R15] [R21]
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_prdata <= 32'h00000000;
        else if (i_psel && !i_penable && !i_pwrite)
            o_prdata <= rd_mux;
    end
endmodule : tec_top

// ### tb/tec_checker.sv
// Concurrent checks on the timer/event counter top-level ports.
// Assumes a bind from the bench top; one clock domain, reset async and active low.
`timescale 1ns/10ps
`include "tec_cfg.svh"
module tec_checker #(
    parameter int CNT_WIDTH = 8
) (
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_external_count_pin,
    input wire logic        i_power_down,
    input wire logic        o_irq,
    input wire logic        o_wakeup,
    input wire logic        o_pin_dir_in
);
    logic en_sh;
    wire  acc    = i_psel && i_penable;
    wire  rd_set = i_psel && !i_penable && !i_pwrite;
    // The enable bit is mirrored here because the checker cannot see inside the block.
    always_ff @(posedge i_clk or negedge i_nrst)
        if (!i_nrst)
            en_sh <= 1'b0;
        else if (acc && i_pwrite && i_paddr == `TEC_OFS_IRQCTL)
            en_sh <= i_pwdata[0];
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence dir_wr;
        acc && i_pwrite && i_paddr == `TEC_OFS_SYSCTL;
    endsequence
    ready_high_a: assert property (o_pready) else $error("pready low");
    pin_dir_a: assert property (dir_wr |=> o_pin_dir_in == $past(i_pwdata[0])) else $error("dir bit");
    wake_pulse_a: assert property (o_wakeup |=> !o_wakeup) else $error("wake too long");
    wake_pd_a: assert property (o_wakeup |-> $past(i_power_down)) else $error("wake when awake");
    irq_masked_a: assert property (!en_sh |-> !o_irq) else $error("irq while disabled");
    wake_irq_a: assert property (o_wakeup && en_sh |-> o_irq) else $error("wake without flag");
    bad_addr_a: assert property (acc && i_paddr[1:0] == 2'b00 |-> o_pslverr == (i_paddr > `TEC_OFS_SYSCTL))
        else $error("slave error");
    rdata_hold_a: assert property (!rd_set |=> $stable(o_prdata)) else $error("read data moved");
endmodule : tec_checker

// ### tb/tec_pulse_src.sv
// Pin source model: drives the external count pin, idle high as with a pull-high.
// Assumes its task is called right after a rising edge of i_clk.
`timescale 1ns/10ps
module tec_pulse_src (
    input  wire logic i_clk,
    output logic      o_pin
);
    initial o_pin = 1'b1;
    // Each pulse gives one fall and one rise; w below 2 would break the spacing limit.
    task automatic pulses(input int n, input int w);
        repeat (n)
        begin
            o_pin <= 1'b0;
            repeat (w) @(posedge i_clk);
            o_pin <= 1'b1;
            repeat (w) @(posedge i_clk);
        end
        repeat (4) @(posedge i_clk);
    endtask : pulses
endmodule : tec_pulse_src

// ### tb/timer_event_counter_io_tb.sv
// Self-checking bench for the timer/event counter: registers, modes, overflow, wake-up.
// Assumes the design, the checker and the pin source model are compiled first.
`timescale 1ns/10ps
`include "tec_cfg.svh"
module timer_event_counter_io_tb;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} tec_row_t;
    logic        i_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_psel = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0;
    logic        i_power_down = 1'b0;
    logic        i_external_count_pin;
    logic [31:0] o_prdata;
    logic        o_pready, o_pslverr, o_irq, o_wakeup, o_pin_dir_in;
    logic [31:0] r;
    logic        e;
    int          mismatches = 0;
    int          checked = 0;
    int          wakes = 0;
    tec_row_t    rows [7] = '{'{`TEC_OFS_CTRL, 32'hF, 32'hF, 1'b0}, '{`TEC_OFS_PRELOAD, 32'h1234565A, 32'h5A, 1'b0},
        '{`TEC_OFS_COUNT, 32'hA5, 32'hA5, 1'b0}, '{`TEC_OFS_STATUS, 32'h3, 32'h1, 1'b0},
        '{`TEC_OFS_IRQCTL, 32'hFFFFFFFF, 32'h1, 1'b0}, '{`TEC_OFS_SYSCTL, 32'h1, 32'h1, 1'b0},
        '{12'h018, 32'hFF, 32'h0, 1'b1}};
    tec_top u_tec_top (.*);
    tec_pulse_src u_tec_pulse_src (.i_clk(i_clk), .o_pin(i_external_count_pin));
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_wakeup === 1'b1) wakes <= wakes + 1;
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    task automatic chk32(input string n, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk32
    task automatic chk1(input string n, input logic x, input logic g);
        chk32(n, {31'h0, x}, {31'h0, g});
    endtask : chk1
    // The request is held until pready is seen high; a stuck slave ends the run.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            mismatches++;
            wrap_up();
        end
        else
        begin
            r = o_prdata;
            e = o_pslverr;
            i_psel <= 1'b0;
            i_penable <= 1'b0;
            @(posedge i_clk);
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk32($sformatf("reg %h", a), x, r);
    endtask : rd
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        chk1("irq", 1'b0, o_irq);
        rd(`TEC_OFS_CTRL, `TEC_CTRL_RST);
        rd(`TEC_OFS_IRQCTL, 32'h0);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            chk1("write error", rows[i].e, e);
            rd(rows[i].a, rows[i].q);
            chk1("read error", rows[i].e, e);
        end
        chk1("pin dir", 1'b1, o_pin_dir_in);
        wr(`TEC_OFS_STATUS, 32'h0);
        wr(`TEC_OFS_IRQCTL, 32'h0);
        wr(`TEC_OFS_COUNT, 32'h0);
        wr(`TEC_OFS_CTRL, 32'h50);
        u_tec_pulse_src.pulses(5, 2);
        rd(`TEC_OFS_COUNT, 32'h5);
        wr(`TEC_OFS_CTRL, 32'h58);
        u_tec_pulse_src.pulses(3, 3);
        rd(`TEC_OFS_COUNT, 32'h8);
        wr(`TEC_OFS_CTRL, 32'h48);
        u_tec_pulse_src.pulses(2, 2);
        rd(`TEC_OFS_COUNT, 32'h8);
        wr(`TEC_OFS_PRELOAD, 32'hFE);
        wr(`TEC_OFS_COUNT, 32'hFE);
        wr(`TEC_OFS_CTRL, 32'h90);
        repeat (6) @(posedge i_clk);
        wr(`TEC_OFS_CTRL, 32'h0);
        rd(`TEC_OFS_STATUS, 32'h1);
        chk1("irq masked", 1'b0, o_irq);
        wr(`TEC_OFS_IRQCTL, 32'h1);
        chk1("irq", 1'b1, o_irq);
        rd(`TEC_OFS_COUNT, 32'hFF);
        wr(`TEC_OFS_STATUS, 32'h0);
        wr(`TEC_OFS_IRQCTL, 32'h0);
        wr(`TEC_OFS_COUNT, 32'h0);
        wr(`TEC_OFS_CTRL, 32'hD0);
        u_tec_pulse_src.pulses(1, 20);
        rd(`TEC_OFS_CTRL, 32'hC0);
        apb(1'b0, `TEC_OFS_COUNT, 32'h0);
        chk1("width", 1'b1, r > 32'd17 && r < 32'd23);
        u_tec_pulse_src.pulses(1, 10);
        rd(`TEC_OFS_COUNT, r);
        // Timer steps every cycle; the preload write access must swallow exactly one step.
        wr(`TEC_OFS_COUNT, 32'h0);
        wr(`TEC_OFS_CTRL, 32'h90);
        wr(`TEC_OFS_PRELOAD, 32'hFE);
        wr(`TEC_OFS_CTRL, 32'h0);
        rd(`TEC_OFS_COUNT, 32'h5);
        wr(`TEC_OFS_IRQCTL, 32'h1);
        wr(`TEC_OFS_COUNT, 32'hFE);
        wr(`TEC_OFS_CTRL, 32'h50);
        i_power_down <= 1'b1;
        u_tec_pulse_src.pulses(2, 2);
        chk32("wakes", 32'd1, wakes);
        chk1("irq", 1'b1, o_irq);
        wr(`TEC_OFS_STATUS, 32'h0);
        u_tec_pulse_src.pulses(2, 2);
        chk32("wakes", 32'd2, wakes);
        wr(`TEC_OFS_STATUS, 32'h1);
        u_tec_pulse_src.pulses(2, 2);
        chk32("wakes", 32'd2, wakes);
        i_power_down <= 1'b0;
        wrap_up();
    end
endmodule : timer_event_counter_io_tb
bind tec_top tec_checker #(.CNT_WIDTH(CNT_WIDTH)) u_tec_checker (.*);
